// file: src/hmp_dev.sv
// Device end of the host micro port
//
// Notes on behaviour
// RL1: Write completes within nine clock periods.
// RL2: Read completes within thirteen clock periods.
// RL3: Separate style: ready flag rises on completion.
// RL4: Shared style: acknowledge pulled low on completion.
// RL5: Latency depends on accessed address.
// RL6: Host drives shared strobe low per access.
// RL7: Host gives 3-bit location address.
// RL8: Reset input is active low.
// RL9: Style pin 0 separate, 1 shared.
// RL10: Acknowledge is open drain, active low. Here separate style drives the pin both ways as ready.
// RL11: Direction pin: read high or write strobe.
// RL12: Device drives data only during selected reads. Here the device keeps driving for one cycle after the host deselects.
// RL13: Host holds address, data, select until completion.

`timescale 1ns/100ps
`include "hmp_regs.svh"

module hmp_dev #(
  parameter int LOCS = `HMP_LOC_CNT
) (
  input wire logic mclk,
  input wire logic nrst,
  hmp_if.dev bus,
  output logic [7:0] loc_q [LOCS],
  output logic busy
);
  //--------------------------------------------------------------
  // Access decode
  //--------------------------------------------------------------
  hmp_pkg::hmp_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic is_rd, next_is_rd;
  logic [7:0] mem [LOCS];
  logic [7:0] rd_q, next_rd_q;
  logic dev_oe_n, next_dev_oe_n;
  logic ack_pull, next_ack_pull;
  logic rdy, next_rdy;
  logic start, start_rd;
  logic [3:0] lat;
  logic wr_en;
  logic next_busy;

  // Wait lengths at the edges of the latency limits
  localparam logic [3:0] MIN_LAT = 4'(`HMP_MIN_CYC);
  localparam logic [3:0] RD_CAP = 4'(`HMP_RD_CYC - 1);
  localparam logic [3:0] WR_CAP = 4'(`HMP_WR_CYC - 1);

  // Access begins on strobe low while selected [RL6] [RL11] [RL9]
  // Either strobe pin opens an access in separate style
  always_comb begin
    if (bus.style == `HMP_STYLE_SHR) begin
      start = !bus.cs_n && !bus.strobe_n;
      start_rd = bus.dir;
    end else begin
      start = !bus.cs_n && (!bus.strobe_n || !bus.dir);
      start_rd = !bus.strobe_n;
    end
  end

  //--------------------------------------------------------------
  // Wait length
  //--------------------------------------------------------------
  // Latency from address: reads add all three address bits, writes only the low two [RL5] [RL1] [RL2]
  // Caps keep the count inside the limits if the map is ever widened
  always_comb begin
    if (start_rd) begin
      lat = MIN_LAT + {1'b0, bus.addr};
      if (lat > RD_CAP) begin
        lat = RD_CAP;
      end
    end else begin
      lat = MIN_LAT + {2'b00, bus.addr[1:0]};
      if (lat > WR_CAP) begin
        lat = WR_CAP;
      end
    end
  end

  //--------------------------------------------------------------
  // Handshake machine
  //--------------------------------------------------------------
  // Idle waits for a strobe, wait counts down, done holds the answer
  // until the host lets go, so the host never sees a half cycle
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_rd = is_rd;
    next_rd_q = rd_q;
    next_dev_oe_n = 1'b1;
    next_ack_pull = 1'b0;
    next_rdy = 1'b0;
    wr_en = 1'b0;
    case (state)
      hmp_pkg::HMP_IDLE: begin
        // Latch the wait length and the direction on the opening edge
        if (start) begin
          next_state = hmp_pkg::HMP_WAIT;
          next_cnt = lat;
          next_is_rd = start_rd;
        end
      end
      hmp_pkg::HMP_WAIT: begin
        // Address and data assumed held until completion [RL13]
        if (!start) begin
          // Strobe dropped early: abandon, nothing is stored
          next_state = hmp_pkg::HMP_IDLE;
          next_cnt = 4'h0;
        end else if (cnt == 4'h0) begin
          // Count spent: show completion and take or give the byte
          next_state = hmp_pkg::HMP_DONE;
          wr_en = !is_rd;
          next_rd_q = mem[bus.addr]; // [RL7]
          next_dev_oe_n = !is_rd; // [RL12]
          next_ack_pull = bus.style == `HMP_STYLE_SHR; // [RL4]
          next_rdy = bus.style == `HMP_STYLE_SEP; // [RL3]
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      hmp_pkg::HMP_DONE: begin
        // Hold completion until host releases strobe
        if (start) begin
          next_dev_oe_n = !is_rd; // [RL12]
          next_ack_pull = bus.style == `HMP_STYLE_SHR; // [RL4]
          next_rdy = bus.style == `HMP_STYLE_SEP; // [RL3]
        end else begin
          next_state = hmp_pkg::HMP_IDLE;
        end
      end
      default: begin
        // Any stray code falls back to idle
        next_state = hmp_pkg::HMP_IDLE;
      end
    endcase
    // Busy is registered so the port shows it straight from a flop
    next_busy = next_state != hmp_pkg::HMP_IDLE;
  end

  //--------------------------------------------------------------
  // State registers
  //--------------------------------------------------------------
  // Register the machine, clear on reset low [RL8]
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= hmp_pkg::HMP_IDLE;
      cnt <= 4'h0;
      is_rd <= 1'b0;
      rd_q <= 8'h00;
      dev_oe_n <= 1'b1;
      ack_pull <= 1'b0;
      rdy <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      is_rd <= next_is_rd;
      rd_q <= next_rd_q;
      dev_oe_n <= next_dev_oe_n;
      ack_pull <= next_ack_pull;
      rdy <= next_rdy;
      busy <= next_busy;
    end
  end

  //--------------------------------------------------------------
  // Location store
  //--------------------------------------------------------------
  // Writes land on the completion edge while the host still holds data
  genvar gi;
  generate
    for (gi = 0; gi < LOCS; gi++) begin : g_loc
      logic [7:0] next_loc;
      // Only the addressed byte takes the bus on a write
      always_comb begin
        next_loc = mem[gi];
        if (wr_en && 32'(bus.addr) == gi) begin
          next_loc = bus.data;
        end
      end

      // One byte per location, cleared by reset [RL8]
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          mem[gi] <= 8'h00;
        end else begin
          mem[gi] <= next_loc;
        end
      end

      // Stored bytes are visible to the rest of the chip
      assign loc_q[gi] = mem[gi];
    end
  endgenerate

  //--------------------------------------------------------------
  // Pin drive
  //--------------------------------------------------------------
  // Read data and its enable come straight from flops [RL12]
  assign bus.dev_d_o = rd_q;
  assign bus.dev_d_oe_n = dev_oe_n;
  // Ready is only ever set in separate style, so it doubles as the
  // low level that the shared acknowledge pulls to [RL3] [RL4]
  assign bus.ack_o = rdy;
  // The enable follows style at once: a flop here would show a stale
  // completion for one cycle after the host changes style [RL10]
  assign bus.ack_oe_n = bus.style == `HMP_STYLE_SEP ? 1'b0 : !ack_pull;
endmodule // hmp_dev

// file: src/hmp_host.sv
// Host end of the host micro port
`timescale 1ns/100ps
`include "hmp_regs.svh"
module hmp_host (
  input wire logic mclk,
  input wire logic nrst,
  hmp_if.host bus,
  input wire logic style_sel,
  input wire logic req,
  input wire logic req_rd,
  input wire logic [2:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic ready,
  output logic done,
  output logic [7:0] rdata
);
  //--------------------------------------------------------------
  // Access sequencer
  //--------------------------------------------------------------
  hmp_pkg::hmp_state_t state, next_state;
  logic [2:0] addr, next_addr;
  logic [7:0] wd, next_wd;
  logic rd, next_rd;
  logic sty, next_sty;
  logic next_done;
  logic [7:0] next_rdata;
  logic complete;
  // Completion seen per style [RL3] [RL4] [RL5]
  assign complete = sty == `HMP_STYLE_SHR ? !bus.ack : bus.ack;
  always_comb begin
    next_state = state;
    next_addr = addr;
    next_wd = wd;
    next_rd = rd;
    next_sty = sty;
    next_done = 1'b0;
    next_rdata = rdata;
    case (state)
      hmp_pkg::HMP_IDLE: begin
        if (req) begin
          next_state = hmp_pkg::HMP_WAIT;
          next_addr = req_addr; // [RL7]
          next_wd = req_wdata;
          next_rd = req_rd;
          next_sty = style_sel; // [RL9]
        end
      end
      hmp_pkg::HMP_WAIT: begin
        // Hold everything until completion [RL13]
        if (complete) begin
          next_state = hmp_pkg::HMP_DONE;
          next_done = 1'b1;
          next_rdata = rd ? bus.data : rdata;
        end
      end
      hmp_pkg::HMP_DONE: begin
        if (!complete) begin
          next_state = hmp_pkg::HMP_IDLE;
        end
      end
      default: begin
        next_state = hmp_pkg::HMP_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= hmp_pkg::HMP_IDLE;
      addr <= 3'h0;
      wd <= 8'h00;
      rd <= 1'b0;
      sty <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      ready <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      wd <= next_wd;
      rd <= next_rd;
      sty <= next_sty;
      done <= next_done;
      rdata <= next_rdata;
      ready <= next_state == hmp_pkg::HMP_IDLE;
    end
  end
  //--------------------------------------------------------------
  // Pin drive
  //--------------------------------------------------------------
  logic act;
  assign act = state == hmp_pkg::HMP_WAIT;
  assign bus.addr = addr;
  assign bus.style = sty;
  assign bus.cs_n = !act;
  // Shared: strobe plus direction; separate: read and write strobes
  assign bus.strobe_n = sty == `HMP_STYLE_SHR ? !act : !(act && rd); // [RL6]
  assign bus.dir = sty == `HMP_STYLE_SHR ? rd : !(act && !rd); // [RL11]
  assign bus.host_d_o = wd;
  assign bus.host_d_oe_n = !(act && !rd); // [RL12]
endmodule // hmp_host

// file: src/hmp_if.sv
// Pin bundle between host and device ends
`timescale 1ns/100ps
interface hmp_if;
  logic [2:0] addr;
  logic cs_n;
  logic strobe_n;
  logic dir;
  logic style;
  logic [7:0] host_d_o;
  logic host_d_oe_n;
  logic [7:0] dev_d_o;
  logic dev_d_oe_n;
  logic ack_o;
  logic ack_oe_n;
  wire [7:0] data;
  wire ack;
  // Resolved bus: pull-up high when nobody drives
  assign data = !host_d_oe_n ? host_d_o :
                (!dev_d_oe_n ? dev_d_o : 8'hff);
  assign ack = !ack_oe_n ? ack_o : 1'b1;
  modport dev (
    input addr, cs_n, strobe_n, dir, style, data,
    output dev_d_o, dev_d_oe_n, ack_o, ack_oe_n
  );
  modport host (
    input data, ack,
    output addr, cs_n, strobe_n, dir, style, host_d_o, host_d_oe_n
  );
endinterface

// file: src/hmp_pkg.sv
// Types shared by both ends of the host micro port
package hmp_pkg;
  typedef enum logic [2:0] {
    HMP_IDLE = 3'b001,
    HMP_WAIT = 3'b010,
    HMP_DONE = 3'b100
  } hmp_state_t;
endpackage

// file: src/hmp_regs.svh
// Constants for the host micro port handshake
`ifndef HMP_REGS_SVH
`define HMP_REGS_SVH
`define HMP_CLK_NS 100
`define HMP_WR_MAX_NS 900
`define HMP_RD_MAX_NS 1300
`define HMP_WR_CYC (`HMP_WR_MAX_NS / `HMP_CLK_NS)
`define HMP_RD_CYC (`HMP_RD_MAX_NS / `HMP_CLK_NS)
`define HMP_MIN_CYC 4
`define HMP_LOC_CNT 8
`define HMP_STYLE_SEP 1'b0
`define HMP_STYLE_SHR 1'b1
`endif

// file: tb/hmp_assertions.sv
// Pin checker for the host micro port
`timescale 1ns/100ps
module hmp_assertions (
  input logic mclk,
  input logic nrst,
  input logic [2:0] addr,
  input logic cs_n,
  input logic strobe_n,
  input logic dir,
  input logic style,
  input logic dev_d_oe_n,
  input logic ack_o,
  input logic ack_oe_n,
  input wire ack
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Access, read and completion decoded from the pins
  logic act;
  logic rd;
  logic rd_act;
  logic comp;
  assign act = !cs_n && (!strobe_n || (!style && !dir));
  assign rd = style ? dir : !strobe_n;
  assign rd_act = act && rd;
  assign comp = style ? !ack : (!ack_oe_n && ack_o);
  // Start of each kind of access
  sequence s_wr_go; $rose(act) && !rd; endsequence
  sequence s_rd_go; $rose(act) && rd; endsequence
  property p_wr_lat; s_wr_go |-> ##[1:9] comp; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("slow write");
  property p_rd_lat; s_rd_go |-> ##[1:13] comp; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("slow read");
  property p_early; $rose(act) |-> !comp [*4]; endproperty
  a_early: assert property (p_early) else $error("early end");
  property p_drop; $fell(act) |=> !comp; endproperty
  a_drop: assert property (p_drop) else $error("late drop");
  property p_od; style && !ack_oe_n |-> !ack_o; endproperty
  a_od: assert property (p_od) else $error("ack driven high");
  property p_rdq; rd_act && comp |-> !dev_d_oe_n; endproperty
  a_rdq: assert property (p_rdq) else $error("no read data");
  property p_quiet; !dev_d_oe_n |-> $past(rd_act); endproperty
  a_quiet: assert property (p_quiet) else $error("stray drive");
  property p_hold; act && !comp |=> act && $stable(addr); endproperty
  a_hold: assert property (p_hold) else $error("host let go");
  property p_rst; $rose(nrst) |-> dev_d_oe_n && !comp; endproperty
  a_rst: assert property (p_rst) else $error("drive in reset");
endmodule // hmp_assertions

// file: tb/host_microport_handshake_test.sv
// Bench joining host and device ends of the micro port
`timescale 1ns/100ps
module host_microport_handshake_test;
  logic mclk;
  logic nrst;
  logic style_sel;
  logic req;
  logic req_rd;
  logic [2:0] req_addr;
  logic [7:0] req_wdata;
  logic ready;
  logic done;
  logic [7:0] rdata;
  logic [7:0] loc_q [8];
  logic busy;
  int miscompares;
  int n_tests;
  int wl [8];
  int rl [8];
  hmp_if u_hmp_if ();
  hmp_dev u_hmp_dev (.mclk(mclk), .nrst(nrst), .bus(u_hmp_if),
    .loc_q(loc_q), .busy(busy));
  hmp_host u_hmp_host (.mclk(mclk), .nrst(nrst), .bus(u_hmp_if),
    .style_sel(style_sel), .req(req), .req_rd(req_rd),
    .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready),
    .done(done), .rdata(rdata));
  hmp_assertions u_hmp_assertions (.mclk(mclk), .nrst(nrst),
    .addr(u_hmp_if.addr), .cs_n(u_hmp_if.cs_n),
    .strobe_n(u_hmp_if.strobe_n), .dir(u_hmp_if.dir),
    .style(u_hmp_if.style), .dev_d_oe_n(u_hmp_if.dev_d_oe_n),
    .ack_o(u_hmp_if.ack_o), .ack_oe_n(u_hmp_if.ack_oe_n),
    .ack(u_hmp_if.ack));
  // Clock of 100 ns period
  always #50 mclk = ~mclk;
  task automatic final_report;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One falling edge with a bound on the wait
  task automatic tick(inout int n);
    @(negedge mclk);
    n++;
    if (n > 40) begin
      miscompares++;
      final_report();
    end
  endtask
  // One access; cyc counts cycles from request to done
  task automatic xfer(input logic rd, input logic [2:0] a,
    input logic [7:0] wd, output int cyc);
    cyc = 0;
    while (ready !== 1'b1) tick(cyc);
    cyc = 0;
    req_rd = rd;
    req_addr = a;
    req_wdata = wd;
    req = 1'b1;
    tick(cyc);
    req = 1'b0;
    while (done !== 1'b1) tick(cyc);
  endtask
  function automatic logic [7:0] pat(int s, int i);
    return 8'h5a ^ 8'(s * 16 + i);
  endfunction
  // Both strobe styles: fill, read back, compare latencies, reset
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    style_sel = 1'b0;
    req = 1'b0;
    req_rd = 1'b0;
    req_addr = 3'h0;
    req_wdata = 8'h00;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    check({7'h00, ready}, 8'h01);
    for (int s = 0; s < 2; s++) begin
      style_sel = s[0];
      for (int i = 0; i < 8; i++) begin
        xfer(1'b0, i[2:0], pat(s, i), wl[i]);
        check(loc_q[i], pat(s, i));
        check({7'h00, busy}, 8'h01);
      end
      for (int i = 0; i < 8; i++) begin
        xfer(1'b1, i[2:0], 8'h00, rl[i]);
        check(rdata, pat(s, i));
      end
      check(8'(rl[7] - rl[0]), 8'h07);
      check(8'(wl[3] - wl[0]), 8'h03);
      check(8'(wl[7] - wl[3]), 8'h00);
      nrst = 1'b0;
      @(negedge mclk);
      check(loc_q[5], 8'h00);
      check({7'h00, ready}, 8'h00);
      check(u_hmp_if.data, 8'hff);
      check({7'h00, u_hmp_if.ack}, 8'h00);
      check({7'h00, busy}, 8'h00);
      nrst = 1'b1;
      @(negedge mclk);
    end
    final_report();
  end
endmodule // host_microport_handshake_test
